// [test/ecfg_eeprom_model.sv]
`timescale 1ns/100ps
module ecfg_eeprom_model (
  input wire logic ee_cs, // chip select
  input wire logic ee_sk, // serial clock
  input wire logic ee_di, // command in
  output logic ee_do // data out
);
  import ecfg_pkg::*;
  logic [15:0] mem [64];
  logic [8:0] cmd = 9'h0;
  logic bad_op;
  int bitn = 0;
  int nwords = 0;
  int dly = 5;
  initial ee_do = 1'b1;
  // command in, one word out msb first
  // words served from the commanded address
  always @(posedge ee_sk)
  begin
    if (ee_cs)
    begin
      bitn = bitn + 1;
      if (bitn <= 9)
        cmd = {cmd[7:0], ee_di};
      bad_op = cmd[8:6] != EE_OP_READ;
      if (bitn == 9)
        nwords = nwords + 1;
      if (bitn == 9)
        ee_do <= #(dly) 1'b0;
      else if (bitn > 9 && bitn <= 25)
        ee_do <= #(dly) mem[cmd[5:0]][25 - bitn] ^ bad_op;
    end
  end
  // released line flips to its inverse
  always @(negedge ee_cs)
  begin
    bitn = 0;
    ee_do <= #(dly) ~ee_do;
  end
endmodule

// [test/ecfg_monitor.sv]
`timescale 1ns/100ps
module ecfg_monitor (
  input wire logic clk, // core clock
  input wire logic nrst, // reset
  input wire logic ee_cs, // memory select
  input wire logic ee_sk, // memory clock
  input wire logic [31:0] bar_base, // base
  input wire logic [31:0] bus_addr, // address
  input wire logic [7:0] bus_wdata, // write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  input wire logic [15:0] bus_rdata, // read data
  input wire logic cfg_ready, // loaded
  input wire logic [15:0] vendor_id, // field
  input wire logic [23:0] class_code, // field
  input wire logic [7:0] eight_x_sampling_select, // per channel
  input wire logic [7:0] chan_reset, // pulses
  input wire logic [ecfg_pkg::CH_BITS-1:0] uart_ch, // channel
  input wire logic [3:0] uart_reg, // index
  input wire logic uart_wr, // reg write
  input wire logic uart_rd, // reg read
  input wire logic rx_pop, // fifo pop
  input wire logic tx_push, // fifo push
  input wire logic [7:0] rx_data, // fifo byte
  input wire logic [7:0] line_status // byte status
);
  import ecfg_pkg::*;
  logic win, sk_q;
  logic [9:0] o;
  logic [7:0] own;
  logic [4:0] nsk, next_nsk;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // window hit, block offset, own channel mask
  assign win = bus_addr[31:13] == bar_base[31:13];
  assign o = bus_addr[9:0];
  assign own = 8'h01 << bus_addr[12:10];
  // count memory clock rises inside a frame
  always_comb
  begin
    next_nsk = ee_cs ? nsk + {4'h0, ee_sk & ~sk_q} : 5'h0;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nsk <= 5'h0;
      sk_q <= 1'b0;
    end
    else
    begin
      nsk <= next_nsk;
      sk_q <= ee_sk;
    end
  end
  // loader framing and address decode
  a_word_frame: assert property ($fell(ee_cs) |-> nsk == 5'h19)
    else $error("frame clock count wrong");
  a_load_stops: assert property (cfg_ready |-> !ee_cs)
    else $error("memory read after last pair");
  a_fields_frozen: assert property (cfg_ready |=> cfg_ready &&
    $stable(vendor_id) && $stable(class_code))
    else $error("fields moved after load");
  a_chan_write: assert property (bus_wr && win && o <= 10'h00f |->
    uart_wr && uart_ch == bus_addr[12:10] && uart_reg == bus_addr[3:0])
    else $error("channel write lost");
  a_strobe_gate: assert property (uart_wr || uart_rd || rx_pop ||
    tx_push |-> win && (o <= 10'h00f || o[9:8] != 2'b00))
    else $error("strobe outside mapped range");
  a_tx_push: assert property (tx_push == (bus_wr && win &&
    o[9:8] == 2'b01))
    else $error("push decode wrong");
  a_rx_pop: assert property (rx_pop == (bus_rd && win &&
    o[9:8] != 2'b00))
    else $error("pop decode wrong");
  a_status_read: assert property (bus_rd && win && o[9] |=>
    bus_rdata == {$past(line_status), $past(rx_data)})
    else $error("byte with status wrong");
  a_rsvd_read: assert property (bus_rd && (!win ||
    (o > 10'h00f && o < 10'h080) || (o > 10'h09a && o < 10'h100))
    |=> bus_rdata == 16'h0)
    else $error("reserved read not zero");
  a_own_bits: assert property (bus_wr && win && o == 10'h088 |=>
    eight_x_sampling_select == (($past(eight_x_sampling_select) &
    ~$past(own)) | ($past(bus_wdata) & $past(own))))
    else $error("foreign channel bit changed");
  a_reset_pulse: assert property (bus_wr && win && o == 10'h08a |=>
    chan_reset == ($past(bus_wdata) & $past(own)))
    else $error("reset pulse wrong");
  // main scenarios reached
  c_ready: cover property ($rose(cfg_ready));
  c_reset: cover property (|chan_reset);
  c_status: cover property (rx_pop && o[9]);
endmodule

// [test/ecfg_top_tb.sv]
`timescale 1ns/100ps
module ecfg_top_tb;
  import ecfg_pkg::*;
  localparam logic [15:0] VEN = 16'h5a17; // arbitrary value
  localparam logic [15:0] DEV = 16'h0e42; // arbitrary value
  logic clk, nrst, ee_cs, ee_sk, ee_di, ee_do, cfg_ready, bus_wr, bus_rd;
  logic uart_wr, uart_rd, rx_pop, tx_push;
  logic [31:0] bar_base, bus_addr;
  logic [15:0] bus_rdata, vendor_id, device_id, subsys_vendor_id, subsys_id;
  logic [15:0] rd;
  logic [23:0] class_code;
  logic [7:0] bus_wdata, eight_x_sampling_select, four_x_sampling_select;
  logic [7:0] sleep_enable, chan_reset, uart_wdata, uart_rdata, rx_data;
  logic [7:0] line_status, tx_data, cr;
  logic [CH_BITS-1:0] uart_ch;
  logic [3:0] uart_reg, st;
  logic [13:0] a;
  logic [9:0] bnd [10] = '{10'h000, 10'h00f, 10'h010, 10'h07f, 10'h09b,
    10'h0ff, 10'h100, 10'h1ff, 10'h200, 10'h3ff};
  integer seed = 55;
  int fail_count = 0;
  int samples_checked = 0;
  int n, b;
  // memory clock period 2*4 cycles = 400 ns
  ecfg_top #(.VENDOR_DEF(VEN), .DEVICE_DEF(DEV), .HALF_CYC(4))
    i_ecfg_top (.*);
  ecfg_eeprom_model i_ecfg_eeprom_model (.*);
  // core clock, 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle; strobes seen mid-cycle, read data one cycle later
  task automatic acc(input logic w, input logic [13:0] ad,
    input logic [7:0] d);
    bus_addr <= bar_base + {18'h0, ad};
    bus_wdata <= d;
    bus_wr <= w;
    bus_rd <= !w;
    uart_rdata <= 8'($random(seed));
    rx_data <= 8'($random(seed));
    line_status <= 8'($random(seed));
    #10;
    st = {uart_wr, uart_rd, rx_pop, tx_push};
    chk({9'h0, uart_ch, uart_reg, uart_wdata, tx_data},
      {9'h0, ad[12:10], ad[3:0], d, d}, "fields");
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #10;
    rd = bus_rdata;
    cr = chan_reset;
    @(posedge clk);
  endtask
  // access one offset and judge strobes and read data
  task automatic dec(input logic w, input logic [13:0] ad);
    logic [3:0] es;
    logic [15:0] er;
    acc(w, ad, 8'($random(seed)));
    es = 4'h0;
    er = 16'h0;
    if (!ad[13] && ad[9:0] <= 10'h00f)
      es = w ? 4'h8 : 4'h4;
    else if (!ad[13] && ad[9:8] != 2'b00 && !w)
      es = 4'h2;
    else if (!ad[13] && ad[9:8] == 2'b01)
      es = 4'h1;
    if (es[2])
      er = {8'h0, uart_rdata};
    if (es[1])
      er = ad[9] ? {line_status, rx_data} : {8'h0, rx_data};
    chk({28'h0, st}, {28'h0, es}, "strobes");
    chk({16'h0, rd}, {16'h0, er}, "read data");
  endtask
  // load n pairs from a fresh reset, pair bad with broken parity
  task automatic boot(input int n, input int bad, input int dly);
    logic [15:0] ex [6];
    logic [15:0] c, v;
    int t, off, k;
    ex = '{VEN, DEV, CLASS_LO_DEF, CLASS_HI_DEF, SUBSYS_DEF, SUBSYS_DEF};
    off = {$random(seed)} % 6;
    for (k = 0; k < 32; k++)
    begin
      t = (k + off) % 6;
      v = k < n ? 16'($random(seed)) : 16'hbeef;
      c = {1'b0, k == n - 1, 6'h0, k < n ? 8'(t) : TGT_VENDOR};
      c[15] = ~^{c[14:0], v} ^ (k == bad);
      if (k < n && k != bad)
        ex[t] = v;
      i_ecfg_eeprom_model.mem[2 * k] = c;
      i_ecfg_eeprom_model.mem[2 * k + 1] = v;
    end
    i_ecfg_eeprom_model.dly = dly;
    i_ecfg_eeprom_model.nwords = 0;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 8000 && cfg_ready !== 1'b1; k++)
      @(posedge clk);
    if (cfg_ready !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: load never ended", $time);
      wrap_up();
    end
    @(posedge clk);
    chk({vendor_id, device_id}, {ex[0], ex[1]}, "ids");
    chk({8'h0, class_code}, {8'h0, ex[3], ex[2][15:8]}, "class");
    chk({subsys_vendor_id, subsys_id}, {ex[4], ex[5]}, "subsys");
    chk(i_ecfg_eeprom_model.nwords, 2 * n, "words read");
    acc(1'b0, {4'h0, 2'b00, DEV_STAT}, 8'h0);
    chk({16'h0, rd}, bad < n ? 32'h8 : 32'h0, "parity flag");
    acc(1'b0, {4'h2, 2'b00, DEV_STAT}, 8'h0);
    chk({16'h0, rd}, 32'h0, "flag cleared");
    $display("load of %0d pairs done", n);
  endtask
  initial
  begin
    logic [7:0] m [4];
    logic [7:0] sreg [4];
    logic [7:0] own, d;
    nrst = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bar_base = 32'h0;
    bus_addr = 32'h0;
    bus_wdata = 8'h0;
    uart_rdata = 8'h0;
    rx_data = 8'h0;
    line_status = 8'h0;
    sreg = '{DEV_8X, DEV_4X, DEV_SLEEP, DEV_RST};
    m = '{8'h0, 8'h0, 8'h0, 8'h0};
    boot(6, 9, 5);
    boot(1, 9, 40);
    boot(5, 2, 5);
    repeat (3)
    begin
      n = 1 + {$random(seed)} % 6;
      b = {$random(seed)} % 8;
      boot(n, b == n - 1 ? 9 : b, 40);
    end
    bar_base <= {19'($random(seed)), 13'h0};
    @(posedge clk);
    // every region edge except the shared register range 080 to 09a, read and write
    foreach (bnd[i])
    begin
      dec(1'b0, {1'b0, 3'($random(seed)), bnd[i]});
      dec(1'b1, {1'b0, 3'($random(seed)), bnd[i]});
    end
    // random blocks, some outside the window
    repeat (300)
    begin
      a = 14'($random(seed));
      a[13] = a[13] & a[12];
      if (a[9:7] == 3'b001)
        a[9:7] = 3'b000;
      dec(1'($random(seed)), a);
    end
    $display("decode sweep done");
    // each block changes only its own bit
    for (int i = 0; i < 64; i++)
    begin
      a = {1'b0, 3'($random(seed)), 2'b00, sreg[i % 4]};
      d = 8'($random(seed));
      own = 8'h01 << a[12:10];
      acc(1'b1, a, d);
      m[i % 4] = (m[i % 4] & ~own) | (d & own);
      chk({8'h0, eight_x_sampling_select, four_x_sampling_select,
        sleep_enable}, {8'h0, m[0], m[1], m[2]}, "own bits");
      if (i % 4 == 3)
        chk({24'h0, cr}, {24'h0, d & own}, "reset pulse");
      acc(1'b0, a ^ 14'h0c00, 8'h0);
      chk({16'h0, rd}, {24'h0, i % 4 == 3 ? 8'h0 : m[i % 4]},
        "mirror");
    end
    $display("shared register test done");
    wrap_up();
  end
endmodule
bind ecfg_top ecfg_monitor i_ecfg_monitor (.*);

// [verilog/ecfg_addr_dec.sv]
`timescale 1ns/100ps
module ecfg_addr_dec (
  input wire logic [31:0] addr, // bus byte address
  input wire logic [31:0] bar, // memory base address register
  output logic hit, // address falls in the window
  output logic [ecfg_pkg::CH_BITS-1:0] ch, // channel of the block
  output logic [ecfg_pkg::BLK_BITS-1:0] ofs, // offset in the block
  output ecfg_pkg::ecfg_region_t region // kind of target
);
  import ecfg_pkg::*;

  assign hit = (addr[31:WIN_BITS] == bar[31:WIN_BITS]);
  assign ch = addr[WIN_BITS-1:BLK_BITS];
  assign ofs = addr[BLK_BITS-1:0];

  always_comb
  begin
    region = ECFG_RGN_NONE;
    if (!hit)
      region = ECFG_RGN_NONE;
    else if (ofs <= OFS_CHREG_HI)
      region = ECFG_RGN_CHAN;
    else if (ofs >= OFS_DEV_LO && ofs <= OFS_DEV_HI)
      region = ECFG_RGN_DEV;
    else if (ofs >= OFS_FIFO_LO && ofs <= OFS_FIFO_HI)
      region = ECFG_RGN_FIFO;
    else if (ofs >= OFS_RXST_LO)
      region = ECFG_RGN_RXST;
  end
endmodule

// [verilog/ecfg_eeprom_rd.sv]
`timescale 1ns/100ps
module ecfg_eeprom_rd #(
  parameter int HALF_CYC = ecfg_pkg::SK_HALF_CYC,
  parameter int GAP_CYC = ecfg_pkg::CS_GAP_CYC
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // pulse: read one word
  input wire logic [ecfg_pkg::EE_ADDR_W-1:0] addr, // word address
  output logic done, // pulse: word valid
  output logic [ecfg_pkg::EE_WORD_W-1:0] word, // word read
  output logic ee_cs, // memory chip select
  output logic ee_sk, // memory serial clock
  output logic ee_di, // serial data to memory
  input wire logic ee_do // serial data from memory
);
  import ecfg_pkg::*;
  localparam int CMD_W = EE_OP_W + EE_ADDR_W;
  localparam int BITS = CMD_W + EE_WORD_W;
  localparam int CNT_W = $clog2(HALF_CYC + GAP_CYC + 1);
  localparam int BIT_W = $clog2(BITS);

  typedef enum {ECFG_R_IDLE, ECFG_R_SHIFT, ECFG_R_GAP} ecfg_rd_state_t;
  ecfg_rd_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [BIT_W-1:0] bitn, next_bitn;
  logic [CMD_W-1:0] cmd, next_cmd;
  logic [EE_WORD_W-1:0] next_word;
  logic phase, next_phase;
  logic pend, next_pend;
  logic next_done;
  logic do_m, do_s;
  logic tick;

  // two-stage synchroniser on the memory data pin
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      do_m <= 1'b0;
      do_s <= 1'b0;
    end
    else
    begin
      do_m <= ee_do;
      do_s <= do_m;
    end
  end

  assign tick = (cnt == CNT_W'(HALF_CYC - 1));

  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_bitn = bitn;
    next_cmd = cmd;
    next_word = word;
    next_phase = phase;
    next_pend = pend;
    next_done = 1'b0;
    unique case (state)
      ECFG_R_IDLE:
      begin
        next_cnt = '0;
        if (start)
          next_cmd = {EE_OP_READ, addr};
        if (start || pend)
        begin
          next_state = ECFG_R_SHIFT;
          next_bitn = '0;
          next_phase = 1'b0;
          next_pend = 1'b0;
        end
      end
      ECFG_R_SHIFT:
      begin
        if (tick)
        begin
          next_cnt = '0;
          next_phase = ~phase;
          // sample data late in the high half, after its rising edge
          if (phase)
          begin
            if (bitn >= BIT_W'(CMD_W))
              next_word = {word[EE_WORD_W-2:0], do_s};
            if (bitn == BIT_W'(BITS - 1))
            begin
              next_state = ECFG_R_GAP;
              next_done = 1'b1;
            end
            else
              next_bitn = bitn + 1'b1;
          end
        end
      end
      ECFG_R_GAP:
      begin
        // a request during the gap is held until the gap ends
        if (start)
        begin
          next_cmd = {EE_OP_READ, addr};
          next_pend = 1'b1;
        end
        // keep select low long enough between words
        if (cnt == CNT_W'(GAP_CYC - 1))
          next_state = ECFG_R_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ECFG_R_IDLE;
      cnt <= '0;
      bitn <= '0;
      cmd <= '0;
      word <= '0;
      phase <= 1'b0;
      pend <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      cmd <= next_cmd;
      word <= next_word;
      phase <= next_phase;
      pend <= next_pend;
      done <= next_done;
    end
  end

  // pins follow the shifter registers
  assign ee_cs = (state == ECFG_R_SHIFT);
  assign ee_sk = (state == ECFG_R_SHIFT) & phase;
  assign ee_di = (state == ECFG_R_SHIFT) && (bitn < BIT_W'(CMD_W)) &&
                 cmd[CMD_W - 1 - int'(bitn)];
endmodule

// [verilog/ecfg_pkg.sv]
package ecfg_pkg;
  // clock and serial memory timing
  localparam int CLK_NS = 50;
  localparam int SK_HALF_NS = 500;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_NS = 250;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  // serial memory organisation
  localparam int EE_WORD_W = 16;
  localparam int EE_ADDR_W = 6;
  localparam int EE_OP_W = 3;
  localparam logic [EE_OP_W-1:0] EE_OP_READ = 3'h6;
  localparam logic [EE_ADDR_W-1:0] EE_LAST_WORD = 6'h3f;
  // control/address word layout
  localparam int PAR_BIT = 15;
  localparam int LAST_BIT = 14;
  localparam int TGT_HI = 7;
  // target codes
  localparam logic [7:0] TGT_VENDOR = 8'h00;
  localparam logic [7:0] TGT_DEVICE = 8'h01;
  localparam logic [7:0] TGT_CLASS_LO = 8'h02;
  localparam logic [7:0] TGT_CLASS_HI = 8'h03;
  localparam logic [7:0] TGT_SUB_VENDOR = 8'h04;
  localparam logic [7:0] TGT_SUB_ID = 8'h05;
  // built-in field defaults
  localparam logic [15:0] CLASS_LO_DEF = 16'h0200;
  localparam logic [15:0] CLASS_HI_DEF = 16'h0700;
  localparam logic [15:0] SUBSYS_DEF = 16'h0000;
  // memory window layout
  localparam int WIN_BITS = 13;
  localparam int BLK_BITS = 10;
  localparam int CH_BITS = WIN_BITS - BLK_BITS;
  localparam int NUM_CH = 8;
  localparam logic [9:0] OFS_CHREG_LO = 10'h000;
  localparam logic [9:0] OFS_CHREG_HI = 10'h00f;
  localparam logic [9:0] OFS_DEV_LO = 10'h080;
  localparam logic [9:0] OFS_DEV_HI = 10'h09a;
  localparam logic [9:0] OFS_FIFO_LO = 10'h100;
  localparam logic [9:0] OFS_FIFO_HI = 10'h1ff;
  localparam logic [9:0] OFS_RXST_LO = 10'h200;
  localparam logic [9:0] OFS_RXST_HI = 10'h3ff;
  // shared device configuration registers, low byte of block offset
  localparam logic [7:0] DEV_8X = 8'h88;
  localparam logic [7:0] DEV_4X = 8'h89;
  localparam logic [7:0] DEV_RST = 8'h8a;
  localparam logic [7:0] DEV_SLEEP = 8'h8b;
  localparam logic [7:0] DEV_STAT = 8'h8e;
  localparam int STAT_PARITY_BIT = 3;
  typedef enum logic [2:0] {
    ECFG_RGN_NONE,
    ECFG_RGN_CHAN,
    ECFG_RGN_DEV,
    ECFG_RGN_FIFO,
    ECFG_RGN_RXST
  } ecfg_region_t;
endpackage

// [verilog/ecfg_top.sv]
// Notes on behaviour
// - memory read as single 16-bit words
// - words come in control word, value pairs
// - bit 15 holds odd parity of pair
// - parity failure sets status bit 3
// - bit 14 marks the final pair
// - codes 0 to 5 select identity fields
// - unnamed fields keep built-in defaults
// - pairs accepted in any order
// - load once before fields are shown
// - 8K window relative to base register
// - 1024-byte block per channel
// - offsets 0 to f reach channel registers
// - shared registers mirrored in every block
// - channel writes only its own bits
// - 0x100 range pops rx, pushes tx
// - 0x200 range reads data with status
// - channels repeat channel 0 layout
`timescale 1ns/100ps
module ecfg_top #(
  parameter logic [15:0] VENDOR_DEF = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_DEF = 16'h0001, // arbitrary value
  parameter int HALF_CYC = ecfg_pkg::SK_HALF_CYC
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  output logic ee_cs, // memory chip select
  output logic ee_sk, // memory serial clock
  output logic ee_di, // serial data to memory
  input wire logic ee_do, // serial data from memory
  input wire logic [31:0] bar_base, // memory base address register
  input wire logic [31:0] bus_addr, // bus byte address
  input wire logic [7:0] bus_wdata, // bus write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [15:0] bus_rdata, // read data, cycle after strobe
  output logic cfg_ready, // identity fields loaded
  output logic [15:0] vendor_id, // vendor identifier
  output logic [15:0] device_id, // device identifier
  output logic [23:0] class_code, // class code
  output logic [15:0] subsys_vendor_id, // subsystem vendor identifier
  output logic [15:0] subsys_id, // subsystem identifier
  output logic [7:0] eight_x_sampling_select, // per channel 8x sampling
  output logic [7:0] four_x_sampling_select, // per channel 4x sampling
  output logic [7:0] sleep_enable, // per channel sleep
  output logic [7:0] chan_reset, // per channel reset pulse
  output logic [ecfg_pkg::CH_BITS-1:0] uart_ch, // channel addressed
  output logic [3:0] uart_reg, // channel register index
  output logic [7:0] uart_wdata, // channel write data
  output logic uart_wr, // channel register write
  output logic uart_rd, // channel register read
  input wire logic [7:0] uart_rdata, // channel register read data
  output logic rx_pop, // pop receive fifo
  input wire logic [7:0] rx_data, // receive fifo head byte
  input wire logic [7:0] line_status, // status of head byte
  output logic tx_push, // push transmit fifo
  output logic [7:0] tx_data // transmit byte
);
  import ecfg_pkg::*;

  typedef enum {
    ECFG_L_REQ_A,
    ECFG_L_WAIT_A,
    ECFG_L_REQ_D,
    ECFG_L_WAIT_D,
    ECFG_L_APPLY,
    ECFG_L_DONE
  } ecfg_ld_state_t;

  ecfg_ld_state_t ld_state, next_ld_state;
  logic [EE_ADDR_W-1:0] ptr, next_ptr;
  logic [15:0] ctl_word, next_ctl_word;
  logic [15:0] val_word, next_val_word;
  logic [15:0] next_vendor_id, next_device_id;
  logic [23:0] next_class_code;
  logic [15:0] next_subsys_vendor_id, next_subsys_id;
  logic next_cfg_ready;
  logic rd_start, rd_done;
  logic [15:0] rd_word;
  logic par_fail;
  logic pair_ok;

  // serial word reader
  ecfg_eeprom_rd #(
    .HALF_CYC(HALF_CYC),
    .GAP_CYC(CS_GAP_CYC)
  ) u_rd (
    .clk(clk),
    .nrst(nrst),
    .start(rd_start),
    .addr(ptr),
    .done(rd_done),
    .word(rd_word),
    .ee_cs(ee_cs),
    .ee_sk(ee_sk),
    .ee_di(ee_di),
    .ee_do(ee_do)
  );

  assign pair_ok = ^{ctl_word, val_word};

  // loader sequencing and field updates
  always_comb
  begin
    next_ld_state = ld_state;
    next_ptr = ptr;
    next_ctl_word = ctl_word;
    next_val_word = val_word;
    next_vendor_id = vendor_id;
    next_device_id = device_id;
    next_class_code = class_code;
    next_subsys_vendor_id = subsys_vendor_id;
    next_subsys_id = subsys_id;
    next_cfg_ready = cfg_ready;
    rd_start = 1'b0;
    par_fail = 1'b0;
    unique case (ld_state)
      ECFG_L_REQ_A:
      begin
        rd_start = 1'b1;
        next_ld_state = ECFG_L_WAIT_A;
      end
      ECFG_L_WAIT_A:
      begin
        if (rd_done)
        begin
          next_ctl_word = rd_word;
          next_ptr = ptr + 1'b1;
          next_ld_state = ECFG_L_REQ_D;
        end
      end
      ECFG_L_REQ_D:
      begin
        rd_start = 1'b1;
        next_ld_state = ECFG_L_WAIT_D;
      end
      ECFG_L_WAIT_D:
      begin
        if (rd_done)
        begin
          next_val_word = rd_word;
          next_ld_state = ECFG_L_APPLY;
        end
      end
      ECFG_L_APPLY:
      begin
        if (!pair_ok)
          par_fail = 1'b1;
        else
        begin
          unique case (ctl_word[TGT_HI:0])
            TGT_VENDOR: next_vendor_id = val_word;
            TGT_DEVICE: next_device_id = val_word;
            TGT_CLASS_LO: next_class_code[7:0] = val_word[15:8];
            TGT_CLASS_HI: next_class_code[23:8] = val_word;
            TGT_SUB_VENDOR: next_subsys_vendor_id = val_word;
            TGT_SUB_ID: next_subsys_id = val_word;
            default: next_vendor_id = vendor_id;
          endcase
        end
        if (ctl_word[LAST_BIT] || ptr == EE_LAST_WORD)
        begin
          next_ld_state = ECFG_L_DONE;
          next_cfg_ready = 1'b1;
        end
        else
        begin
          next_ptr = ptr + 1'b1;
          next_ld_state = ECFG_L_REQ_A;
        end
      end
      ECFG_L_DONE:
        next_ld_state = ECFG_L_DONE;
    endcase
  end

  // loader registers; built-in defaults at reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ld_state <= ECFG_L_REQ_A;
      ptr <= '0;
      ctl_word <= '0;
      val_word <= '0;
      vendor_id <= VENDOR_DEF;
      device_id <= DEVICE_DEF;
      class_code <= {CLASS_HI_DEF, CLASS_LO_DEF[15:8]};
      subsys_vendor_id <= SUBSYS_DEF;
      subsys_id <= SUBSYS_DEF;
      cfg_ready <= 1'b0;
    end
    else
    begin
      ld_state <= next_ld_state;
      ptr <= next_ptr;
      ctl_word <= next_ctl_word;
      val_word <= next_val_word;
      vendor_id <= next_vendor_id;
      device_id <= next_device_id;
      class_code <= next_class_code;
      subsys_vendor_id <= next_subsys_vendor_id;
      subsys_id <= next_subsys_id;
      cfg_ready <= next_cfg_ready;
    end
  end

  // window decode
  logic win_hit;
  logic [CH_BITS-1:0] dec_ch;
  logic [BLK_BITS-1:0] dec_ofs;
  ecfg_region_t dec_rgn;
  logic [7:0] ch_mask;
  logic [7:0] dev_ofs;

  ecfg_addr_dec u_dec (
    .addr(bus_addr),
    .bar(bar_base),
    .hit(win_hit),
    .ch(dec_ch),
    .ofs(dec_ofs),
    .region(dec_rgn)
  );

  assign ch_mask = 8'h01 << dec_ch;
  assign dev_ofs = dec_ofs[7:0];

  assign uart_ch = dec_ch;
  assign uart_reg = dec_ofs[3:0];
  assign uart_wdata = bus_wdata;
  assign uart_wr = bus_wr && (dec_rgn == ECFG_RGN_CHAN);
  assign uart_rd = bus_rd && (dec_rgn == ECFG_RGN_CHAN);
  assign rx_pop = bus_rd && (dec_rgn == ECFG_RGN_FIFO ||
                             dec_rgn == ECFG_RGN_RXST);
  assign tx_push = bus_wr && (dec_rgn == ECFG_RGN_FIFO);
  assign tx_data = bus_wdata;

  // shared device configuration registers
  logic dev_wr, dev_rd;
  logic status_par, next_status_par;
  logic [7:0] next_eight_x, next_four_x, next_sleep, next_chan_reset;
  logic [15:0] rd_value, next_rdata;

  assign dev_wr = bus_wr && (dec_rgn == ECFG_RGN_DEV);
  assign dev_rd = bus_rd && (dec_rgn == ECFG_RGN_DEV);

  always_comb
  begin
    next_eight_x = eight_x_sampling_select;
    next_four_x = four_x_sampling_select;
    next_sleep = sleep_enable;
    next_chan_reset = 8'h00;
    next_status_par = status_par;
    if (dev_wr)
    begin
      unique case (dev_ofs)
        DEV_8X:
          next_eight_x = (eight_x_sampling_select & ~ch_mask) |
                         (bus_wdata & ch_mask);
        DEV_4X:
          next_four_x = (four_x_sampling_select & ~ch_mask) |
                        (bus_wdata & ch_mask);
        DEV_SLEEP:
          next_sleep = (sleep_enable & ~ch_mask) | (bus_wdata & ch_mask);
        DEV_RST:
          next_chan_reset = bus_wdata & ch_mask;
        default: next_chan_reset = 8'h00;
      endcase
    end
    // status clears on read; a new failure wins
    if (dev_rd && dev_ofs == DEV_STAT)
      next_status_par = 1'b0;
    if (par_fail)
      next_status_par = 1'b1;
  end

  // read data selection
  always_comb
  begin
    rd_value = 16'h0000;
    unique case (dec_rgn)
      ECFG_RGN_CHAN: rd_value = {8'h00, uart_rdata};
      ECFG_RGN_FIFO: rd_value = {8'h00, rx_data};
      ECFG_RGN_RXST: rd_value = {line_status, rx_data};
      ECFG_RGN_DEV:
      begin
        unique case (dev_ofs)
          DEV_8X: rd_value = {8'h00, eight_x_sampling_select};
          DEV_4X: rd_value = {8'h00, four_x_sampling_select};
          DEV_SLEEP: rd_value = {8'h00, sleep_enable};
          DEV_STAT: rd_value = 16'(status_par) << STAT_PARITY_BIT;
          default: rd_value = 16'h0000;
        endcase
      end
      ECFG_RGN_NONE: rd_value = 16'h0000;
    endcase
    next_rdata = bus_rd ? rd_value : 16'h0000;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eight_x_sampling_select <= 8'h00;
      four_x_sampling_select <= 8'h00;
      sleep_enable <= 8'h00;
      chan_reset <= 8'h00;
      status_par <= 1'b0;
      bus_rdata <= 16'h0000;
    end
    else
    begin
      eight_x_sampling_select <= next_eight_x;
      four_x_sampling_select <= next_four_x;
      sleep_enable <= next_sleep;
      chan_reset <= next_chan_reset;
      status_par <= next_status_par;
      bus_rdata <= next_rdata;
    end
  end
endmodule
